// >>> trl_task_reg.sv
// Task register with its load sequencer: takes a selector from the load
// instruction or a task switch, fetches and checks the descriptor from
// the global table, marks it busy and fills the hidden portion.
// Assumes a memory port that holds a request until acknowledged and
// returns the addressed qword on the acknowledge cycle.
module trl_task_reg
    import trl_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         protection_on_i,
    input  wire trl_mode_t    mode_i,
    input  wire logic [1:0]   cpl_i,
    input  wire logic         ltr_req_i,
    input  wire logic         switch_req_i,
    input  wire logic [15:0]  new_sel_i,
    input  wire logic [63:0]  gdt_base_i,
    input  wire logic [15:0]  gdt_limit_i,
    input  wire logic         mem_ack_i,
    input  wire logic [63:0]  mem_rdata_i,
    input  wire logic         access_req_i,
    input  wire logic [31:0]  access_ofs_i,
    input  wire logic [3:0]   access_len_i,
    output trl_mem_req_t      mem_req_o,
    output logic [15:0]       task_register_o,
    output trl_hidden_t       hidden_o,
    output logic              busy_o,
    output logic              done_o,
    output trl_fault_t        fault_o,
    output logic              access_valid_o,
    output logic [63:0]       access_addr_o,
    output logic              access_fault_o
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ_LO,
        ST_READ_HI,
        ST_CHECK,
        ST_MARK
    } trl_state_t;

    trl_state_t   state_q;
    trl_mem_req_t mem_q;
    trl_fault_t   fault_q;
    trl_hidden_t  hidden_q;
    trl_mode_t    mode_q;
    logic [15:0]  sel_q;
    logic [15:0]  tr_q;
    logic         is_sw_q;
    logic [63:0]  desc_lo_q;
    logic [31:0]  desc_hi_q;
    logic [63:0]  desc_addr_q;
    logic         done_q;
    logic         busy_q;
    logic         acc_v_q;
    logic         acc_f_q;
    logic [63:0]  acc_a_q;

    logic [12:0]  req_idx;
    logic         req_any;
    logic [16:0]  req_last;
    logic [16:0]  req_room;
    logic         pre_gp;
    logic [63:0]  req_addr;
    logic [31:0]  dec_limit;
    logic [31:0]  dec_base;
    logic [3:0]   dec_kind;
    logic [1:0]   dec_dpl;
    logic         dec_bad;
    logic         dec_busy;
    logic         dec_short;
    logic [32:0]  acc_end;
    logic [63:0]  acc_full;

    // Decoder for the fetched low qword
    trl_desc_dec u_dec (
        .desc_i     (desc_lo_q),
        .mode_i     (mode_q),
        .limit_o    (dec_limit),
        .base_o     (dec_base),
        .kind_o     (dec_kind),
        .dpl_o      (dec_dpl),
        .bad_type_o (dec_bad),
        .busy_o     (dec_busy),
        .short_o    (dec_short)
    );

    // Request side checks; a 16-byte descriptor must fit whole in the table
    assign req_any  = ltr_req_i | switch_req_i;
    assign req_idx  = new_sel_i[SEL_IDX_HI:SEL_IDX_LO];
    assign req_room = (mode_i == MODE_LONG64) ? DESC16_LAST : DESC8_LAST;
    assign req_last = {1'b0, req_idx, 3'b000} + req_room;
    assign req_addr = gdt_base_i + {48'h0, req_idx, 3'b000};

    // Any of these refuses the request before memory is touched
    always_comb begin
        pre_gp = 1'b0;
        if (!protection_on_i) begin
            pre_gp = 1'b1;
        end
        if (new_sel_i[SEL_TI_BIT]) begin
            pre_gp = 1'b1;
        end
        if (req_idx == 13'h0000) begin
            pre_gp = 1'b1;
        end
        if (req_last > {1'b0, gdt_limit_i}) begin
            pre_gp = 1'b1;
        end
        // Long mode has no hardware task switch to perform
        if (switch_req_i && !ltr_req_i && mode_i != MODE_LEGACY) begin
            pre_gp = 1'b1;
        end
    end

    // Sequencer; faults return to idle without committing anything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (req_any && !pre_gp) begin
                        state_q <= ST_READ_LO;
                    end
                end
                ST_READ_LO: begin
                    if (mem_ack_i) begin
                        // Only 64-bit mode reads the second half
                        state_q <= (mode_q == MODE_LONG64) ? ST_READ_HI : ST_CHECK;
                    end
                end
                ST_READ_HI: begin
                    if (mem_ack_i) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (dec_bad || dec_busy || (is_sw_q && dec_short)) begin
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_MARK;
                    end
                end
                ST_MARK: begin
                    if (mem_ack_i) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Request capture; the privilege field is taken from the current level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q       <= 16'h0000;
            is_sw_q     <= 1'b0;
            mode_q      <= MODE_LEGACY;
            desc_addr_q <= 64'h0;
        end else if (state_q == ST_IDLE && req_any) begin
            sel_q       <= {new_sel_i[SEL_IDX_HI:SEL_TI_BIT], cpl_i};
            is_sw_q     <= switch_req_i & ~ltr_req_i;
            mode_q      <= mode_i;
            desc_addr_q <= req_addr;
        end
    end

    // Descriptor capture from memory
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            desc_lo_q <= 64'h0;
            desc_hi_q <= 32'h0;
        end else begin
            if (state_q == ST_IDLE) begin
                desc_hi_q <= 32'h0;
            end
            if (state_q == ST_READ_LO && mem_ack_i) begin
                desc_lo_q <= mem_rdata_i;
            end
            if (state_q == ST_READ_HI && mem_ack_i) begin
                desc_hi_q <= mem_rdata_i[31:0];
            end
        end
    end

    // Memory port: reads of the table, then a single busy write-back.
    // Only the table entry is accessed, never the segment itself.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    mem_q.valid <= req_any & ~pre_gp;
                    mem_q.write <= 1'b0;
                    mem_q.addr  <= req_addr;
                    mem_q.wdata <= 32'h0;
                end
                ST_READ_LO: begin
                    if (mem_ack_i) begin
                        mem_q.valid <= (mode_q == MODE_LONG64);
                        mem_q.addr  <= desc_addr_q + HI_QW_OFS;
                    end
                end
                ST_READ_HI: begin
                    if (mem_ack_i) begin
                        mem_q.valid <= 1'b0;
                    end
                end
                ST_CHECK: begin
                    // Busy is only ever set here, never cleared
                    mem_q.valid <= ~(dec_bad | dec_busy | (is_sw_q & dec_short));
                    mem_q.write <= 1'b1;
                    mem_q.addr  <= desc_addr_q + BUSY_DW_OFS;
                    mem_q.wdata <= desc_lo_q[63:32] | (32'h1 << DW_BUSY_BIT);
                end
                ST_MARK: begin
                    if (mem_ack_i) begin
                        mem_q <= '0;
                    end
                end
                default: begin
                    mem_q <= '0;
                end
            endcase
        end
    end

    // Commit of visible and hidden parts once the busy write lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tr_q     <= 16'h0000;
            hidden_q <= '0;
        end else if (state_q == ST_MARK && mem_ack_i) begin
            tr_q           <= sel_q;
            hidden_q.limit <= dec_limit;
            hidden_q.kind  <= dec_kind | 4'(1 << (D_BUSY_BIT - D_TYPE_LO));
            hidden_q.dpl   <= dec_dpl;
            // Compatibility and legacy loads leave the upper base zero
            hidden_q.base  <= {desc_hi_q, dec_base};
        end
    end

    // Fault reporting, one cycle per refused load or switch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= '0;
        end else begin
            fault_q <= '0;
            if (state_q == ST_IDLE && req_any && pre_gp) begin
                fault_q.gp   <= 1'b1;
                fault_q.code <= new_sel_i & ERR_MASK;
            end else if (state_q == ST_CHECK) begin
                if (dec_bad || dec_busy) begin
                    fault_q.gp   <= 1'b1;
                    fault_q.code <= sel_q & ERR_MASK;
                end else if (is_sw_q && dec_short) begin
                    fault_q.ts   <= 1'b1;
                    fault_q.code <= sel_q & ERR_MASK;
                end
            end
        end
    end

    // Busy follows the sequencer's next state, so the port is a flop, not a decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            busy_q <= req_any & ~pre_gp;
        end else if (state_q == ST_CHECK) begin
            busy_q <= ~(dec_bad | dec_busy | (is_sw_q & dec_short));
        end else if (state_q == ST_MARK) begin
            busy_q <= ~mem_ack_i;
        end
    end

    // Completion pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_MARK) & mem_ack_i;
        end
    end

    // Accesses to segment data: anything past the limit is refused.
    // Legacy mode wraps at 4G since the upper base is ignored.
    assign acc_end  = {1'b0, access_ofs_i} + {29'h0, access_len_i} - 33'h1;
    assign acc_full = hidden_q.base + {32'h0, access_ofs_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_v_q <= 1'b0;
            acc_f_q <= 1'b0;
            acc_a_q <= 64'h0;
        end else begin
            acc_v_q <= 1'b0;
            acc_f_q <= 1'b0;
            if (access_req_i && access_len_i != 4'h0) begin
                if (acc_end > {1'b0, hidden_q.limit}) begin
                    acc_f_q <= 1'b1;
                end else begin
                    acc_v_q <= 1'b1;
                    if (mode_i == MODE_LEGACY) begin
                        acc_a_q <= {32'h0, acc_full[31:0]};
                    end else begin
                        acc_a_q <= acc_full;
                    end
                end
            end
        end
    end

    // Outputs straight from registers
    assign mem_req_o       = mem_q;
    assign task_register_o = tr_q;
    assign hidden_o        = hidden_q;
    assign busy_o          = busy_q;
    assign done_o          = done_q;
    assign fault_o         = fault_q;
    assign access_valid_o  = acc_v_q;
    assign access_addr_o   = acc_a_q;
    assign access_fault_o  = acc_f_q;

endmodule : trl_task_reg

// >>> trl_pkg.sv
// Package for the task register load and check logic: selector and
// descriptor layout, type codes, limits, modes and carrier structs.
// Assumes one core clock and a memory port that returns whole qwords.
// Notes on behaviour
// - Task features only with protection on
// - Selector bits 15:3 index global table
// - Local-table reference raises general protection
// - Selector bits 1:0 take current privilege
// - Switch with limit below 67h: invalid segment
// - Access past limit raises general protection
// - Switch checks only the minimum limit
// - Descriptor bit 41, upper dword bit 9, is the busy flag
// - Transfer to busy task raises general protection
// - Long mode accepts only 64-bit task types
// - Long mode load marks available type busy
// - Long mode never clears the busy flag
// - Long mode 16-bit type raises general protection
// - Selector write fetches descriptor into hidden part
// - Load instruction and task switch update register
// - Legacy mode ignores upper 32 base bits
// - Upper base loaded only from 64-bit mode
// - Long modes address with full 64-bit base
// - Load marks busy, touches no segment fields
package trl_pkg;

    // Selector fields
    localparam int SEL_IDX_HI = 15;
    localparam int SEL_IDX_LO = 3;
    localparam int SEL_TI_BIT = 2;
    localparam int SEL_RPL_HI = 1;

    // Descriptor fields within the low qword
    localparam int D_LIM_LO_HI  = 15;
    localparam int D_BASE_LO_HI = 39;
    localparam int D_BASE_LO_LO = 16;
    localparam int D_TYPE_HI    = 43;
    localparam int D_TYPE_LO    = 40;
    localparam int D_SYS_BIT    = 44;
    localparam int D_DPL_HI     = 46;
    localparam int D_DPL_LO     = 45;
    localparam int D_PRES_BIT   = 47;
    localparam int D_LIM_HI_HI  = 51;
    localparam int D_LIM_HI_LO  = 48;
    localparam int D_GRAN_BIT   = 55;
    localparam int D_BASE_HI_HI = 63;
    localparam int D_BASE_HI_LO = 56;
    // Busy flag: bit 9 of the upper dword, bit 1 of the type field
    localparam int D_BUSY_BIT   = 41;
    localparam int DW_BUSY_BIT  = 9;

    // Task segment type codes
    localparam logic [3:0] TYPE_AVL16 = 4'h1;
    localparam logic [3:0] TYPE_BSY16 = 4'h3;
    localparam logic [3:0] TYPE_AVL32 = 4'h9;
    localparam logic [3:0] TYPE_BSY32 = 4'hb;

    // Limits and address steps
    localparam logic [31:0] MIN_LIMIT   = 32'h0000_0067;
    localparam logic [11:0] GRAN_FILL   = 12'hfff;
    localparam logic [63:0] HI_QW_OFS   = 64'h0000_0000_0000_0008;
    localparam logic [63:0] BUSY_DW_OFS = 64'h0000_0000_0000_0004;
    localparam logic [16:0] DESC8_LAST  = 17'h0_0007;
    localparam logic [16:0] DESC16_LAST = 17'h0_000f;
    localparam logic [15:0] ERR_MASK    = 16'hfffc;

    // Operating mode of the core
    typedef enum logic [1:0] {
        MODE_LEGACY,
        MODE_COMPAT,
        MODE_LONG64
    } trl_mode_t;

    // Memory request toward the descriptor tables
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [63:0] addr;
        logic [31:0] wdata;
    } trl_mem_req_t;

    // Fault report
    typedef struct packed {
        logic        gp;
        logic        ts;
        logic [15:0] code;
    } trl_fault_t;

    // Hidden portion of the task register
    typedef struct packed {
        logic [63:0] base;
        logic [31:0] limit;
        logic [3:0]  kind;
        logic [1:0]  dpl;
    } trl_hidden_t;

endpackage : trl_pkg

// >>> trl_desc_dec.sv
// Descriptor decoder: splits a task segment descriptor into fields and
// judges its type, busy flag and limit for the current mode.
// Assumes a purely combinational use inside the load sequencer.
module trl_desc_dec
    import trl_pkg::*;
(
    input  wire logic [63:0] desc_i,
    input  wire trl_mode_t   mode_i,
    output logic [31:0]      limit_o,
    output logic [31:0]      base_o,
    output logic [3:0]       kind_o,
    output logic [1:0]       dpl_o,
    output logic             bad_type_o,
    output logic             busy_o,
    output logic             short_o
);
    logic [19:0] raw_lim;
    logic        long_m;

    // Field extraction; granularity scales the limit by 4K
    assign raw_lim = {desc_i[D_LIM_HI_HI:D_LIM_HI_LO], desc_i[D_LIM_LO_HI:0]};
    assign limit_o = desc_i[D_GRAN_BIT] ? {raw_lim, GRAN_FILL} : {12'h000, raw_lim};
    assign base_o  = {desc_i[D_BASE_HI_HI:D_BASE_HI_LO],
                      desc_i[D_BASE_LO_HI:D_BASE_LO_LO]};
    assign kind_o  = desc_i[D_TYPE_HI:D_TYPE_LO];
    assign dpl_o   = desc_i[D_DPL_HI:D_DPL_LO];
    assign long_m  = (mode_i != MODE_LEGACY);

    // Busy flag sits in descriptor bit 41, bit 9 of the upper dword
    assign busy_o  = desc_i[D_BUSY_BIT];

    // Only system task types pass; long mode drops the 16-bit pair
    always_comb begin
        bad_type_o = desc_i[D_SYS_BIT] | ~desc_i[D_PRES_BIT];
        case (kind_o)
            TYPE_AVL32, TYPE_BSY32: bad_type_o = bad_type_o;
            TYPE_AVL16, TYPE_BSY16: bad_type_o = 1'b1 & long_m | bad_type_o;
            default:                bad_type_o = 1'b1;
        endcase
    end

    // Minimum size check, the only limit test a switch makes
    assign short_o = (limit_o < MIN_LIMIT);

endmodule : trl_desc_dec

// >>> trl_task_reg_sva.sv
// Checker for the task register load sequencer: pre-checks, descriptor
// fetch address, busy marking, commit contents and segment access answers.
// Sees only the ports of trl_task_reg; bound to it at the foot of the file.
module trl_task_reg_sva
    import trl_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         protection_on_i,
    input wire trl_mode_t    mode_i,
    input wire logic [1:0]   cpl_i,
    input wire logic         ltr_req_i,
    input wire logic         switch_req_i,
    input wire logic [15:0]  new_sel_i,
    input wire logic [63:0]  gdt_base_i,
    input wire logic         access_req_i,
    input wire logic [31:0]  access_ofs_i,
    input wire logic [3:0]   access_len_i,
    input wire trl_mem_req_t mem_req_o,
    input wire logic [15:0]  task_register_o,
    input wire trl_hidden_t  hidden_o,
    input wire logic         busy_o,
    input wire logic         done_o,
    input wire trl_fault_t   fault_o,
    input wire logic         access_valid_o,
    input wire logic [63:0]  access_addr_o,
    input wire logic         access_fault_o
);
    logic        take;
    logic        acc;
    logic        over;
    logic [63:0] sum;
    logic [15:0] sel_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Accepted request, and the figures an access answer depends on
    assign take = !busy_o && (ltr_req_i || switch_req_i);
    assign acc  = access_req_i && access_len_i != 4'h0;
    assign over = ({1'b0, access_ofs_i} + {29'h0, access_len_i} - 33'h1)
                  > {1'b0, hidden_o.limit};
    assign sum  = hidden_o.base + {32'h0, access_ofs_i};

    // Selector as it must land: privilege bits replaced at request time
    always_ff @(posedge clk_i) begin
        if (rst_i)
            sel_q <= 16'h0;
        else if (take)
            sel_q <= {new_sel_i[15:2], cpl_i};
    end

    prot_off_gp_a: assert property (take && !protection_on_i |=> fault_o.gp)
        else $error("no protection fault with protection off");
    table_sel_gp_a: assert property (take && new_sel_i[2] |=> fault_o.gp)
        else $error("no protection fault for local table selector");
    read_index_a: assert property (take ##1 mem_req_o.valid |-> !mem_req_o.write
        && mem_req_o.addr == gdt_base_i + {48'h0, $past(new_sel_i[15:3]), 3'h0})
        else $error("descriptor fetched from wrong entry");
    commit_sel_a: assert property (done_o |-> task_register_o == sel_q && hidden_o.kind[1])
        else $error("committed selector or busy kind wrong");
    fault_keep_a: assert property ((fault_o.gp || fault_o.ts) |->
        $stable(task_register_o) && $stable(hidden_o) && fault_o.code == (sel_q & ERR_MASK))
        else $error("fault changed the register or gave a wrong code");
    busy_mark_a: assert property (mem_req_o.valid && mem_req_o.write |->
        mem_req_o.wdata[DW_BUSY_BIT])
        else $error("descriptor store without busy flag");
    access_limit_a: assert property (acc |=> access_fault_o == $past(over)
        && access_valid_o == !$past(over))
        else $error("access verdict against limit wrong");
    access_addr_a: assert property (acc ##1 access_valid_o |-> access_addr_o ==
        ($past(mode_i) == MODE_LEGACY ? {32'h0, $past(sum[31:0])} : $past(sum)))
        else $error("access address wrong for mode");

    // Main scenarios reached
    cover property (done_o);
    cover property (fault_o.ts);
    cover property (access_fault_o);

endmodule : trl_task_reg_sva

bind trl_task_reg trl_task_reg_sva trl_task_reg_sva_inst (.*);

// >>> test_task_register_load_check.sv
// Self-checking bench for trl_task_reg: a table of loads and switches,
// then segment accesses, a request while busy and a second reset.
// The bench plays the memory holding the global descriptor table.
module test_task_register_load_check
    import trl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int          DLY   = 5;
    localparam logic [63:0] GLOBAL_DESCRIPTOR_TABLE   = 64'h0000_0000_0001_0000;
    localparam logic [31:0] HI_DW = 32'h0000_0001;

    typedef struct {
        logic        prot;
        trl_mode_t   mode;
        logic        sw;
        logic [1:0]  cpl;
        logic [15:0] sel;
        logic [3:0]  typ;
        logic [31:0] base;
        logic [31:0] lim;
        logic [1:0]  res;
    } trl_row_t;

    logic         clk_i, rst_i, protection_on_i, ltr_req_i, switch_req_i;
    logic         mem_ack_i, access_req_i, busy_o, done_o, access_valid_o, access_fault_o;
    logic [1:0]   cpl_i, got;
    logic [3:0]   access_len_i;
    logic [15:0]  new_sel_i, gdt_limit_i, task_register_o;
    logic [31:0]  access_ofs_i;
    logic [63:0]  gdt_base_i, mem_rdata_i, access_addr_o, mem_a;
    trl_mode_t    mode_i;
    trl_mem_req_t mem_req_o;
    trl_hidden_t  hidden_o;
    trl_fault_t   fault_o;
    int           miscompares, n_checks;
    logic [63:0]  mem [logic [63:0]];

    // Result column: 0 commit, 1 protection fault, 2 invalid segment fault
    trl_row_t rows [12] = '{
        '{1, MODE_LEGACY, 0, 0, 16'h0008, TYPE_AVL32, 32'h1234_5678, 32'h67, 0},
        '{1, MODE_COMPAT, 0, 1, 16'h0018, TYPE_AVL32, 32'h0000_a000, 32'h80, 0},
        '{1, MODE_LONG64, 0, 0, 16'h0028, TYPE_AVL32, 32'h0000_c000, 32'h67, 0},
        '{1, MODE_LEGACY, 1, 0, 16'h0038, TYPE_AVL32, 32'h0000_d000, 32'h66, 2},
        '{1, MODE_LEGACY, 1, 0, 16'h0048, TYPE_AVL32, 32'h0000_e000, 32'h67, 0},
        '{1, MODE_LEGACY, 0, 0, 16'h0008, TYPE_AVL32, 32'h1234_5678, 32'h67, 1},
        '{1, MODE_LONG64, 0, 0, 16'h0058, TYPE_AVL16, 32'h0000_5000, 32'h67, 1},
        '{1, MODE_LEGACY, 0, 0, 16'h006c, TYPE_AVL32, 32'h0000_6000, 32'h67, 1},
        '{0, MODE_LEGACY, 0, 0, 16'h0078, TYPE_AVL32, 32'h0000_7000, 32'h67, 1},
        '{1, MODE_LEGACY, 0, 2, 16'h0088, TYPE_AVL16, 32'h0000_f000, 32'h67, 0},
        '{1, MODE_LONG64, 0, 0, 16'h0028, TYPE_AVL32, 32'h0000_c000, 32'h67, 1},
        '{1, MODE_LONG64, 0, 3, 16'h0098, TYPE_AVL32, 32'hffff_ff00, 32'hfff, 0}
    };

    trl_task_reg trl_task_reg_inst (.*);

    // Free-running core clock, 50 ns period
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Memory acks in the same cycle a request shows, DLY after its edge; stores land on the ack
    always @(posedge clk_i) begin
        #DLY;
        if (mem_req_o.valid && !mem_ack_i) begin
            mem_a = {mem_req_o.addr[63:3], 3'h0};
            if (mem_req_o.write && mem_req_o.addr[2])
                mem[mem_a][63:32] = mem_req_o.wdata;
            else if (mem_req_o.write)
                mem[mem_a][31:0] = mem_req_o.wdata;
            mem_rdata_i = mem.exists(mem_a) ? mem[mem_a] : 64'h0;
            mem_ack_i = 1'b1;
        end else begin
            mem_ack_i = 1'b0;
        end
    end

    function automatic logic [63:0] mk_desc(logic [31:0] b, logic [31:0] l, logic [3:0] t);
        mk_desc = {b[31:24], 4'h0, l[19:16], 1'b1, 2'h0, 1'b0, t, b[23:0], l[15:0]};
    endfunction : mk_desc

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (!ok) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic close_out();
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // Waits a bounded time for a commit or a fault and records which
    task automatic wait_end();
        got = 2'd3;
        for (int k = 0; k < 40 && got == 2'd3; k++) begin
            if (done_o === 1'b1)
                got = 2'd0;
            else if (fault_o.gp === 1'b1)
                got = 2'd1;
            else if (fault_o.ts === 1'b1)
                got = 2'd2;
            else begin
                @(posedge clk_i);
                #DLY;
            end
        end
        if (got == 2'd3) begin
            check(1'b0, "no commit or fault in time");
            close_out();
        end
    endtask : wait_end

    // Request held high across the next edge; it stays on for chains
    task automatic acc(input trl_mode_t m, input logic [31:0] o, input logic [3:0] n,
                       input logic f, input logic [63:0] ea);
        mode_i = m;
        access_ofs_i = o;
        access_len_i = n;
        access_req_i = 1'b1;
        @(posedge clk_i);
        #DLY;
        check(access_fault_o === f, "access fault");
        check(access_valid_o === (!f && n != 4'h0), "access valid");
        if (access_valid_o === 1'b1)
            check(access_addr_o === ea, "access address");
    endtask : acc

    initial begin
        trl_row_t    r;
        logic [63:0] a, old_d, eb;
        logic [15:0] old_tr;
        trl_hidden_t old_h;
        // Acknowledge and read data belong to the memory process alone
        {ltr_req_i, switch_req_i, access_req_i, cpl_i, access_len_i} = '0;
        {protection_on_i, new_sel_i, access_ofs_i} = '0;
        miscompares = 0;
        n_checks = 0;
        rst_i = 1'b1;
        mode_i = MODE_LEGACY;
        gdt_base_i = GLOBAL_DESCRIPTOR_TABLE;
        gdt_limit_i = 16'h00ff;
        foreach (rows[i]) begin
            a = GLOBAL_DESCRIPTOR_TABLE + {48'h0, rows[i].sel[15:3], 3'h0};
            mem[a] = mk_desc(rows[i].base, rows[i].lim, rows[i].typ);
            mem[a + 64'h8] = {32'h0, HI_DW};
        end
        repeat (5) @(posedge clk_i);
        #DLY;
        rst_i = 1'b0;
        // Table of loads and switches, each judged against the rows
        foreach (rows[i]) begin
            r = rows[i];
            a = GLOBAL_DESCRIPTOR_TABLE + {48'h0, r.sel[15:3], 3'h0};
            old_d = mem[a];
            old_tr = task_register_o;
            old_h = hidden_o;
            eb = (r.mode == MODE_LONG64) ? {HI_DW, r.base} : {32'h0, r.base};
            @(posedge clk_i);
            #DLY;
            {protection_on_i, cpl_i, new_sel_i} = {r.prot, r.cpl, r.sel};
            mode_i = r.mode;
            {ltr_req_i, switch_req_i} = {!r.sw, r.sw};
            @(posedge clk_i);
            #DLY;
            {ltr_req_i, switch_req_i} = 2'b00;
            wait_end();
            check(got === r.res, "commit or fault kind");
            if (r.res == 2'd0) begin
                check(task_register_o === {r.sel[15:2], r.cpl}, "visible selector");
                check(hidden_o === {eb, r.lim, r.typ | 4'h2, 2'h0}, "hidden part");
                if (!r.sw)
                    check(mem[a] === (old_d | (64'h1 << D_BUSY_BIT)), "busy mark");
            end else begin
                check(task_register_o === old_tr && hidden_o === old_h, "state kept");
                check(mem[a] === old_d, "descriptor kept");
            end
        end
        // Accesses against base 1_ffff_ff00 and limit fff, back to back
        acc(MODE_LONG64, 32'h0000_0ff8, 4'h8, 1'b0, 64'h2_0000_0ef8);
        acc(MODE_LEGACY, 32'h0000_0ff8, 4'h8, 1'b0, 64'h0_0000_0ef8);
        acc(MODE_LONG64, 32'h0000_0ff9, 4'h8, 1'b1, 64'h0);
        acc(MODE_COMPAT, 32'h8000_0000, 4'h1, 1'b1, 64'h0);
        acc(MODE_COMPAT, 32'h0000_0010, 4'h0, 1'b0, 64'h0);
        access_req_i = 1'b0;
        // A switch offered while the load is in flight must be dropped
        mem[GLOBAL_DESCRIPTOR_TABLE + 64'h00a8] = mk_desc(32'h0000_b000, 32'h67, TYPE_AVL32);
        mode_i = MODE_LEGACY;
        {cpl_i, new_sel_i, ltr_req_i} = {2'h0, 16'h00a8, 1'b1};
        @(posedge clk_i);
        #DLY;
        {ltr_req_i, switch_req_i, new_sel_i} = {1'b0, 1'b1, 16'h0008};
        @(posedge clk_i);
        #DLY;
        switch_req_i = 1'b0;
        wait_end();
        check(got === 2'd0 && task_register_o === 16'h00a8, "request while busy");
        // Second reset in mid-run clears the register
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #DLY;
        rst_i = 1'b0;
        check(task_register_o === 16'h0 && hidden_o === '0 && busy_o === 1'b0, "reset state");
        close_out();
    end

endmodule : test_task_register_load_check
